// ==== core/sdrt_cfg_bank.sv ====
// Rate, output source, signal detect and eye monitor configuration bank of the serial video retimer.
//
// Summary of operation
// - Override codes 01, 10, 11 force fixed rates.
// - Code 00 auto-detects video rates, not 125M.
// - Override bit chooses register code over strap pins.
// - Output A field applies only under strap override.
// - A: 00/11 reclocked-or-bypass, 01 bypass, 10 mute.
// - Output B field applies only under strap override.
// - B: clock/mute, reclocked/bypass, mute, bypass.
// - Threshold codes 011-110 select rising detect levels.
// - Override clear: eye DACs stepped automatically.
// - Override set: DACs take register values.
// - Filter bit selects high-rate eye mode.
// - Phase field drives DAC only when overridden.
// - Voltage field drives DAC only when overridden.
// - Legacy mute and clock bits apply without override.
// - Muted output holds the chosen logic level.
`timescale 1ns/1ps
`include "sdrt_map.svh"
module sdrt_cfg_bank
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [`SDRT_ADDR_W-1:0] reg_addr,
    input wire logic [`SDRT_DATA_W-1:0] reg_wdata,
    output logic [`SDRT_DATA_W-1:0] reg_rdata,
    input wire logic [1:0] rate_pins,
    input wire logic [1:0] out_a_pin_source,
    input wire logic [1:0] out_b_pin_source,
    input wire logic locked,
    input wire logic recl_data,
    input wire logic byp_data,
    input wire logic rec_clock,
    input wire logic [5:0] eye_auto_phase,
    input wire logic [5:0] eye_auto_voltage,
    output sdrt_pkg::sdrt_rate_t rate_mode,
    output logic rate_auto_detect,
    output logic serial_out_a,
    output logic serial_out_b,
    output logic [2:0] detect_threshold_code,
    output logic detect_preset_bit,
    output logic detect_clear_bit,
    output sdrt_pkg::sdrt_dac_t eye_phase_dac,
    output sdrt_pkg::sdrt_dac_t eye_voltage_dac,
    output logic eye_high_rate_filter
);

    localparam int SYNC_W = 10;

    logic rst_meta_q, rst_n;
    logic [SYNC_W-1:0] pin_raw, pin_meta_q, pin_q;
    logic [1:0] rate_pin_q;
    logic [7:0] strap_ctrl_q, legacy_out_q, device_ctrl_q, rate_mode_reg_q, rate_ovr_q, out_src_q;
    logic [7:0] rsvd_1f_q, detect_q, rsvd_21_q, eye_one_q, eye_two_q;
    logic [7:0] rdata_d, rdata_q;
    logic [1:0] rate_d, rate_q;
    logic [5:0] phase_q, voltage_q;
    logic strap_override, rate_code_override, eye_dac_override, mute_level;
    sdrt_pkg::sdrt_src_t src_a, src_b;

    sdrt_mux_if a_if ();
    sdrt_mux_if b_if ();

    // Reset is released through two flip-flops so every register leaves reset on the same edge.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // Pins and the analog retimer signals arrive unsynchronised and pass two flip-flops each.
    assign pin_raw = {rate_pins[1], rec_clock, byp_data, recl_data, locked,
                      out_b_pin_source, out_a_pin_source, rate_pins[0]};

    generate
        for (genvar i = 0; i < SYNC_W; i++)
        begin : g_sync
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    pin_meta_q[i] <= 1'b0;
                    pin_q[i] <= 1'b0;
                end
                else
                begin
                    pin_meta_q[i] <= pin_raw[i];
                    pin_q[i] <= pin_meta_q[i];
                end
            end
        end
    endgenerate

    assign rate_pin_q = {pin_q[9], pin_q[0]};

    // Register writes; every byte is stored whole so reserved fields read back what was written.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strap_ctrl_q <= `SDRT_RST_STRAP_CTRL;
            legacy_out_q <= `SDRT_RST_LEGACY_OUT;
            device_ctrl_q <= `SDRT_RST_DEVICE_CTRL;
            rate_mode_reg_q <= `SDRT_RST_RATE_MODE;
            rate_ovr_q <= `SDRT_RST_RATE_OVR;
            out_src_q <= `SDRT_RST_OUT_SRC;
            rsvd_1f_q <= `SDRT_RST_RSVD_1F;
            detect_q <= `SDRT_RST_DETECT;
            rsvd_21_q <= `SDRT_RST_RSVD_21;
            eye_one_q <= `SDRT_RST_EYE_ONE;
            eye_two_q <= `SDRT_RST_EYE_TWO;
        end
        else if (reg_wr_en)
        begin
            if (reg_addr == `SDRT_ADDR_STRAP_CTRL)
            begin
                strap_ctrl_q <= reg_wdata;
            end
            else if (reg_addr == `SDRT_ADDR_LEGACY_OUT)
            begin
                legacy_out_q <= reg_wdata;
            end
            else if (reg_addr == `SDRT_ADDR_DEVICE_CTRL)
            begin
                device_ctrl_q <= reg_wdata;
            end
            else if (reg_addr == `SDRT_ADDR_RATE_MODE)
            begin
                rate_mode_reg_q <= reg_wdata;
            end
            else if (reg_addr == `SDRT_ADDR_RATE_OVR)
            begin
                rate_ovr_q <= reg_wdata;
            end
            else if (reg_addr == `SDRT_ADDR_OUT_SRC)
            begin
                out_src_q <= reg_wdata;
            end
            else if (reg_addr == `SDRT_ADDR_RSVD_1F)
            begin
                rsvd_1f_q <= reg_wdata;
            end
            else if (reg_addr == `SDRT_ADDR_DETECT)
            begin
                detect_q <= reg_wdata;
            end
            else if (reg_addr == `SDRT_ADDR_RSVD_21)
            begin
                rsvd_21_q <= reg_wdata;
            end
            else if (reg_addr == `SDRT_ADDR_EYE_ONE)
            begin
                eye_one_q <= reg_wdata;
            end
            else if (reg_addr == `SDRT_ADDR_EYE_TWO)
            begin
                eye_two_q <= reg_wdata;
            end
        end
    end

    // Read data is registered; an unmapped address reads as zero.
    always_comb
    begin
        rdata_d = `SDRT_READ_ZERO;
        if (reg_addr == `SDRT_ADDR_STRAP_CTRL)
        begin
            rdata_d = strap_ctrl_q;
        end
        else if (reg_addr == `SDRT_ADDR_LEGACY_OUT)
        begin
            rdata_d = legacy_out_q;
        end
        else if (reg_addr == `SDRT_ADDR_DEVICE_CTRL)
        begin
            rdata_d = device_ctrl_q;
        end
        else if (reg_addr == `SDRT_ADDR_RATE_MODE)
        begin
            rdata_d = rate_mode_reg_q;
        end
        else if (reg_addr == `SDRT_ADDR_RATE_OVR)
        begin
            rdata_d = rate_ovr_q;
        end
        else if (reg_addr == `SDRT_ADDR_OUT_SRC)
        begin
            rdata_d = out_src_q;
        end
        else if (reg_addr == `SDRT_ADDR_RSVD_1F)
        begin
            rdata_d = rsvd_1f_q;
        end
        else if (reg_addr == `SDRT_ADDR_DETECT)
        begin
            rdata_d = detect_q;
        end
        else if (reg_addr == `SDRT_ADDR_RSVD_21)
        begin
            rdata_d = rsvd_21_q;
        end
        else if (reg_addr == `SDRT_ADDR_EYE_ONE)
        begin
            rdata_d = eye_one_q;
        end
        else if (reg_addr == `SDRT_ADDR_EYE_TWO)
        begin
            rdata_d = eye_two_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_q <= `SDRT_READ_ZERO;
        end
        else if (reg_rd_en)
        begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign strap_override = strap_ctrl_q[`SDRT_BIT_STRAP_OVR];
    assign rate_code_override = rate_ovr_q[`SDRT_BIT_RATE_OVR];
    assign eye_dac_override = eye_one_q[`SDRT_BIT_EYE_OVR];
    assign mute_level = device_ctrl_q[`SDRT_BIT_MUTE_LEVEL];

    // Rate mode follows the straps unless the register code overrides them.
    assign rate_d = rate_code_override ? rate_mode_reg_q[`SDRT_RATE_HI:`SDRT_RATE_LO] : rate_pin_q;

    // Eye DACs take the register fields only under override, else the automatic stepping values.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rate_q <= 2'h0;
            phase_q <= 6'h00;
            voltage_q <= 6'h00;
        end
        else
        begin
            rate_q <= rate_d;
            phase_q <= eye_dac_override ? eye_one_q[`SDRT_DAC_HI:`SDRT_DAC_LO] : eye_auto_phase;
            voltage_q <= eye_dac_override ? eye_two_q[`SDRT_DAC_HI:`SDRT_DAC_LO] : eye_auto_voltage;
        end
    end

    assign rate_mode = sdrt_pkg::sdrt_rate_t'(rate_q);
    assign rate_auto_detect = (rate_mode == sdrt_pkg::SDRT_RATE_AUTO);
    assign eye_phase_dac = phase_q;
    assign eye_voltage_dac = voltage_q;
    assign eye_high_rate_filter = eye_one_q[`SDRT_BIT_EYE_FILTER];
    assign detect_threshold_code = detect_q[`SDRT_DET_HI:`SDRT_DET_LO];
    assign detect_preset_bit = detect_q[`SDRT_BIT_DET_PRESET];
    assign detect_clear_bit = detect_q[`SDRT_BIT_DET_CLEAR];

    // Effective source codes; without strap override the pins and legacy bits decide.
    always_comb
    begin
        if (strap_override)
        begin
            src_a = out_src_q[`SDRT_SRC_A_HI:`SDRT_SRC_A_LO];
            src_b = out_src_q[`SDRT_SRC_B_HI:`SDRT_SRC_B_LO];
        end
        else
        begin
            src_a = pin_q[2:1];
            src_b = legacy_out_q[`SDRT_BIT_LEGACY_CLK] ? `SDRT_SRC_DEFAULT : pin_q[4:3];
            if (!legacy_out_q[`SDRT_BIT_LEGACY_RUN])
            begin
                src_a = `SDRT_SRC_MUTE;
                src_b = `SDRT_SRC_MUTE;
            end
        end
    end

    assign a_if.src = src_a;
    assign a_if.is_b = 1'b0;
    assign a_if.locked = pin_q[5];
    assign a_if.recl_data = pin_q[6];
    assign a_if.byp_data = pin_q[7];
    assign a_if.rec_clock = pin_q[8];
    assign a_if.mute_level = mute_level;
    assign b_if.src = src_b;
    assign b_if.is_b = 1'b1;
    assign b_if.locked = pin_q[5];
    assign b_if.recl_data = pin_q[6];
    assign b_if.byp_data = pin_q[7];
    assign b_if.rec_clock = pin_q[8];
    assign b_if.mute_level = mute_level;

    sdrt_out_mux u_mux_a
    (
        .clk(clk),
        .rst_n(rst_n),
        .port_if(a_if)
    );

    sdrt_out_mux u_mux_b
    (
        .clk(clk),
        .rst_n(rst_n),
        .port_if(b_if)
    );

    assign serial_out_a = a_if.out;
    assign serial_out_b = b_if.out;

    a_rate_override: assert property (@(posedge clk) disable iff (!rst_n)
        rate_code_override |=> rate_q == $past(rate_mode_reg_q[1:0]))
        else $error("rate mode does not follow the register code under override");
    a_rate_strap: assert property (@(posedge clk) disable iff (!rst_n)
        !rate_code_override |=> rate_q == $past(rate_pin_q))
        else $error("rate mode does not follow the strap pins");
    a_rate_auto_flag: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> rate_auto_detect == ($past(rate_code_override) ? ($past(rate_mode_reg_q[1:0]) == 2'h0)
                                                                  : ($past(rate_pin_q) == 2'h0)))
        else $error("auto detect flag disagrees with the selected rate code");
    a_eye_phase_ovr: assert property (@(posedge clk) disable iff (!rst_n)
        eye_dac_override |=> eye_phase_dac == $past(eye_one_q[5:0]))
        else $error("phase DAC does not take the register value");
    a_eye_auto_step: assert property (@(posedge clk) disable iff (!rst_n)
        !eye_dac_override |=> eye_phase_dac == $past(eye_auto_phase) && eye_voltage_dac == $past(eye_auto_voltage))
        else $error("eye DACs do not follow automatic stepping");
    a_eye_volt_ovr: assert property (@(posedge clk) disable iff (!rst_n)
        eye_dac_override |=> eye_voltage_dac == $past(eye_two_q[5:0]))
        else $error("voltage DAC does not take the register value");
    a_eye_filter: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr_en && reg_addr == 8'h22 |=> eye_high_rate_filter == $past(reg_wdata[6]))
        else $error("high rate filter bit not applied after write");
    a_out_a_muted: assert property (@(posedge clk) disable iff (!rst_n)
        src_a == 2'h2 |=> serial_out_a == $past(mute_level))
        else $error("muted output A not at mute level");
    a_out_b_bypass: assert property (@(posedge clk) disable iff (!rst_n)
        src_b == 2'h3 |=> serial_out_b == $past(pin_q[7]))
        else $error("output B does not carry bypassed data");
    a_legacy_mute: assert property (@(posedge clk) disable iff (!rst_n)
        !strap_override && !legacy_out_q[1] |-> src_a == 2'h2 && src_b == 2'h2)
        else $error("legacy mute not applied in pin mode");
    a_src_a_ovr: assert property (@(posedge clk) disable iff (!rst_n)
        strap_override |-> src_a == out_src_q[6:5] && src_b == out_src_q[4:3])
        else $error("source fields ignored under strap override");
    a_thresh_write: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr_en && reg_addr == 8'h20 |=> detect_threshold_code == $past(reg_wdata[5:3]))
        else $error("threshold code not updated by write");

    c_rate_override: cover property (@(posedge clk) disable iff (!rst_n) rate_code_override && rate_q == 2'h3);
    c_eye_override: cover property (@(posedge clk) disable iff (!rst_n) eye_dac_override ##1 !eye_dac_override);
    c_out_b_clock: cover property (@(posedge clk) disable iff (!rst_n) src_b == 2'h0 && pin_q[5]);
    c_mute_high: cover property (@(posedge clk) disable iff (!rst_n) src_a == 2'h2 && mute_level);

endmodule : sdrt_cfg_bank

// ==== core/sdrt_map.svh ====
// Register offsets, field positions, reset values and codes of the rate, output and eye configuration bank.
`ifndef SDRT_MAP_SVH
`define SDRT_MAP_SVH

`define SDRT_ADDR_W 8
`define SDRT_DATA_W 8

`define SDRT_ADDR_STRAP_CTRL 8'h09
`define SDRT_ADDR_LEGACY_OUT 8'h13
`define SDRT_ADDR_DEVICE_CTRL 8'h14
`define SDRT_ADDR_RATE_MODE 8'h1c
`define SDRT_ADDR_RATE_OVR 8'h1d
`define SDRT_ADDR_OUT_SRC 8'h1e
`define SDRT_ADDR_RSVD_1F 8'h1f
`define SDRT_ADDR_DETECT 8'h20
`define SDRT_ADDR_RSVD_21 8'h21
`define SDRT_ADDR_EYE_ONE 8'h22
`define SDRT_ADDR_EYE_TWO 8'h23

`define SDRT_RST_STRAP_CTRL 8'h00
`define SDRT_RST_LEGACY_OUT 8'h02
`define SDRT_RST_DEVICE_CTRL 8'h13
`define SDRT_RST_RATE_MODE 8'h24
`define SDRT_RST_RATE_OVR 8'h80
`define SDRT_RST_OUT_SRC 8'h0b
`define SDRT_RST_RSVD_1F 8'h55
`define SDRT_RST_DETECT 8'h18
`define SDRT_RST_RSVD_21 8'h05
`define SDRT_RST_EYE_ONE 8'h00
`define SDRT_RST_EYE_TWO 8'h40
`define SDRT_READ_ZERO 8'h00

`define SDRT_BIT_STRAP_OVR 5
`define SDRT_BIT_LEGACY_RUN 1
`define SDRT_BIT_LEGACY_CLK 0
`define SDRT_BIT_MUTE_LEVEL 7
`define SDRT_BIT_RATE_OVR 0
`define SDRT_BIT_EYE_OVR 7
`define SDRT_BIT_EYE_FILTER 6
`define SDRT_BIT_DET_PRESET 7
`define SDRT_BIT_DET_CLEAR 6

`define SDRT_RATE_HI 1
`define SDRT_RATE_LO 0
`define SDRT_SRC_A_HI 6
`define SDRT_SRC_A_LO 5
`define SDRT_SRC_B_HI 4
`define SDRT_SRC_B_LO 3
`define SDRT_DET_HI 5
`define SDRT_DET_LO 3
`define SDRT_DAC_HI 5
`define SDRT_DAC_LO 0

`define SDRT_SRC_DEFAULT 2'h0
`define SDRT_SRC_ALT 2'h1
`define SDRT_SRC_MUTE 2'h2
`define SDRT_SRC_LAST 2'h3

`endif

// ==== core/sdrt_pkg.sv ====
// Types shared by the configuration bank and its output source selector.
package sdrt_pkg;

    typedef enum logic [1:0] {
        SDRT_RATE_AUTO = 2'h0,
        SDRT_RATE_SD = 2'h1,
        SDRT_RATE_HD3G = 2'h2,
        SDRT_RATE_LOW = 2'h3
    } sdrt_rate_t;

    typedef logic [1:0] sdrt_src_t;

    typedef logic [5:0] sdrt_dac_t;

endpackage : sdrt_pkg

// ==== core/sdrt_mux_if.sv ====
// Connection between the configuration bank and one serial output source selector.
`timescale 1ns/1ps
interface sdrt_mux_if;
    sdrt_pkg::sdrt_src_t src;
    logic is_b;
    logic locked;
    logic recl_data;
    logic byp_data;
    logic rec_clock;
    logic mute_level;
    logic out;

    modport cfg (output src, output is_b, output locked, output recl_data, output byp_data,
                 output rec_clock, output mute_level, input out);
    modport mux (input src, input is_b, input locked, input recl_data, input byp_data,
                 input rec_clock, input mute_level, output out);
endinterface : sdrt_mux_if

// ==== core/sdrt_out_mux.sv ====
// Registered source selector for one serial output.
`timescale 1ns/1ps
`include "sdrt_map.svh"
module sdrt_out_mux
(
    input wire logic clk,
    input wire logic rst_n,
    sdrt_mux_if.mux port_if
);

    logic out_d;
    logic out_q;

    always_comb
    begin
        out_d = port_if.mute_level;
        if (!port_if.is_b)
        begin
            if (port_if.src == `SDRT_SRC_ALT)
            begin
                out_d = port_if.byp_data;
            end
            else if (port_if.src != `SDRT_SRC_MUTE)
            begin
                out_d = port_if.locked ? port_if.recl_data : port_if.byp_data;
            end
        end
        else
        begin
            if (port_if.src == `SDRT_SRC_DEFAULT)
            begin
                out_d = port_if.locked ? port_if.rec_clock : port_if.mute_level;
            end
            else if (port_if.src == `SDRT_SRC_ALT)
            begin
                out_d = port_if.locked ? port_if.recl_data : port_if.byp_data;
            end
            else if (port_if.src == `SDRT_SRC_LAST)
            begin
                out_d = port_if.byp_data;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_q <= 1'b0;
        end
        else
        begin
            out_q <= out_d;
        end
    end

    assign port_if.out = out_q;

endmodule : sdrt_out_mux

// ==== bench/test_sdrt_cfg_bank.sv ====
// Self-checking testbench of the rate, output source, signal detect and eye monitor configuration bank.
`timescale 1ns/1ps
`include "sdrt_map.svh"
module test_sdrt_cfg_bank;
    localparam int CYCLE_LIMIT = 20000;
    localparam logic [0:10][7:0] MAP_ADDR = {`SDRT_ADDR_STRAP_CTRL, `SDRT_ADDR_LEGACY_OUT,
        `SDRT_ADDR_DEVICE_CTRL, `SDRT_ADDR_RATE_MODE, `SDRT_ADDR_RATE_OVR, `SDRT_ADDR_OUT_SRC,
        `SDRT_ADDR_RSVD_1F, `SDRT_ADDR_DETECT, `SDRT_ADDR_RSVD_21, `SDRT_ADDR_EYE_ONE, `SDRT_ADDR_EYE_TWO};
    localparam logic [0:10][7:0] MAP_RST = {`SDRT_RST_STRAP_CTRL, `SDRT_RST_LEGACY_OUT,
        `SDRT_RST_DEVICE_CTRL, `SDRT_RST_RATE_MODE, `SDRT_RST_RATE_OVR, `SDRT_RST_OUT_SRC,
        `SDRT_RST_RSVD_1F, `SDRT_RST_DETECT, `SDRT_RST_RSVD_21, `SDRT_RST_EYE_ONE, `SDRT_RST_EYE_TWO};
    logic clk, rst_b, reg_wr_en, reg_rd_en, locked, recl_data, byp_data, rec_clock;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val, wr_val;
    logic [1:0] rate_pins, out_a_pin_source, out_b_pin_source;
    logic [5:0] eye_auto_phase, eye_auto_voltage, pv, vv;
    sdrt_pkg::sdrt_rate_t rate_mode;
    sdrt_pkg::sdrt_dac_t eye_phase_dac, eye_voltage_dac;
    logic rate_auto_detect, serial_out_a, serial_out_b, detect_preset_bit, detect_clear_bit, eye_high_rate_filter;
    logic [2:0] detect_threshold_code;
    logic [1:0] code_a, code_b;
    int n_mismatch, num_checks, cycles;
    integer seed;
    sdrt_cfg_bank dut (.clk(clk), .rst_b(rst_b), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rate_pins(rate_pins),
        .out_a_pin_source(out_a_pin_source), .out_b_pin_source(out_b_pin_source), .locked(locked),
        .recl_data(recl_data), .byp_data(byp_data), .rec_clock(rec_clock), .eye_auto_phase(eye_auto_phase),
        .eye_auto_voltage(eye_auto_voltage), .rate_mode(rate_mode), .rate_auto_detect(rate_auto_detect),
        .serial_out_a(serial_out_a), .serial_out_b(serial_out_b), .detect_threshold_code(detect_threshold_code),
        .detect_preset_bit(detect_preset_bit), .detect_clear_bit(detect_clear_bit), .eye_phase_dac(eye_phase_dac),
        .eye_voltage_dac(eye_voltage_dac), .eye_high_rate_filter(eye_high_rate_filter));
    always #12.5 clk = ~clk;
    task automatic end_of_test();
        if (n_mismatch == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test
    always @(posedge clk)
    begin
        cycles = cycles + 1;
        if (cycles == CYCLE_LIMIT)
        begin
            n_mismatch = n_mismatch + 1;
            end_of_test();
        end
    end
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic settle(input int n);
        repeat (n) @(negedge clk);
    endtask : settle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr_en = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd_en = 1'b0;
        d = reg_rdata;
    endtask : rd
    // Expected source of one serial output for a source code, including the mute level.
    function automatic logic out_exp(input logic [1:0] c, input logic is_b, input logic lk, input logic rdat,
                                     input logic bdat, input logic ck, input logic ml);
        case (c)
            2'h0: return is_b ? (lk ? ck : ml) : (lk ? rdat : bdat);
            2'h1: return is_b ? (lk ? rdat : bdat) : bdat;
            2'h2: return ml;
            default: return is_b ? bdat : (lk ? rdat : bdat);
        endcase
    endfunction : out_exp
    // Drives random retimer status and data, then compares both outputs after synchronisation.
    task automatic check_outputs(input logic [1:0] ca, input logic [1:0] cb, input logic ml);
        {locked, recl_data, byp_data, rec_clock} = 4'($random(seed));
        settle(5);
        chk("serial_out_a", {7'h00, serial_out_a}, {7'h00, out_exp(ca, 1'b0, locked, recl_data, byp_data, rec_clock, ml)});
        chk("serial_out_b", {7'h00, serial_out_b}, {7'h00, out_exp(cb, 1'b1, locked, recl_data, byp_data, rec_clock, ml)});
    endtask : check_outputs
    initial
    begin
        clk = 1'b0;
        rst_b = 1'b0;
        {reg_wr_en, reg_rd_en, locked, recl_data, byp_data, rec_clock} = 6'h00;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        {rate_pins, out_a_pin_source, out_b_pin_source} = 6'h00;
        eye_auto_phase = 6'h00;
        eye_auto_voltage = 6'h00;
        n_mismatch = 0;
        num_checks = 0;
        cycles = 0;
        seed = 32'h1770_8519;
        settle(10);
        rst_b = 1'b1;
        settle(3);
        for (int i = 0; i < 11; i++)
        begin
            rd(MAP_ADDR[i], rd_val);
            chk("reset value", rd_val, MAP_RST[i]);
        end
        for (int i = 0; i < 11; i++)
        begin
            wr_val = 8'($random(seed));
            wr(MAP_ADDR[i], wr_val);
            rd(MAP_ADDR[i], rd_val);
            chk("readback", rd_val, wr_val);
        end
        wr(8'h30, 8'hff);
        rd(8'h30, rd_val);
        chk("unmapped read", rd_val, `SDRT_READ_ZERO);
        rd(8'h1b, rd_val);
        chk("unmapped read", rd_val, `SDRT_READ_ZERO);
        // Rate pins steer the mode while the override is clear, the register code afterwards.
        wr(`SDRT_ADDR_RATE_MODE, 8'h24);
        wr(`SDRT_ADDR_RATE_OVR, 8'h80);
        for (int p = 0; p < 4; p++)
        begin
            rate_pins = 2'(p);
            settle(4);
            chk("rate_mode pins", {6'h00, rate_mode}, 8'(p));
            chk("rate_auto_detect", {7'h00, rate_auto_detect}, {7'h00, p == 0});
        end
        wr(`SDRT_ADDR_RATE_OVR, 8'h81);
        for (int c = 0; c < 4; c++)
        begin
            rate_pins = 2'(3 - c);
            wr(`SDRT_ADDR_RATE_MODE, {6'b001001, 2'(c)});
            settle(4);
            chk("rate_mode register", {6'h00, rate_mode}, 8'(c));
            chk("rate_auto_detect", {7'h00, rate_auto_detect}, {7'h00, c == 0});
        end
        // Register source fields under strap override; pin codes must be ignored.
        wr(`SDRT_ADDR_STRAP_CTRL, 8'h20);
        for (int ml = 0; ml < 2; ml++)
        begin
            wr(`SDRT_ADDR_DEVICE_CTRL, {1'(ml), 7'h13});
            for (int c = 0; c < 16; c++)
            begin
                code_a = 2'(c >> 2);
                code_b = 2'(c);
                {out_a_pin_source, out_b_pin_source} = 4'($random(seed));
                wr(`SDRT_ADDR_OUT_SRC, {1'b0, code_a, code_b, 3'b011});
                check_outputs(code_a, code_b, 1'(ml));
            end
        end
        // Pin mode with legacy run and clock bits; register fields set to mute are ignored.
        wr(`SDRT_ADDR_STRAP_CTRL, 8'h00);
        wr(`SDRT_ADDR_OUT_SRC, 8'h53);
        for (int leg = 0; leg < 4; leg++)
        begin
            wr(`SDRT_ADDR_LEGACY_OUT, 8'(leg));
            for (int k = 0; k < 6; k++)
            begin
                {out_a_pin_source, out_b_pin_source} = 4'($random(seed));
                code_a = leg[1] ? out_a_pin_source : `SDRT_SRC_MUTE;
                code_b = !leg[1] ? `SDRT_SRC_MUTE : (leg[0] ? `SDRT_SRC_DEFAULT : out_b_pin_source);
                check_outputs(code_a, code_b, 1'b1);
            end
        end
        // Threshold codes and the preset and clear bits pass to the detector.
        for (int c = 3; c < 7; c++)
        begin
            wr(`SDRT_ADDR_DETECT, {2'(c), 3'(c), 3'b000});
            settle(2);
            chk("detect_threshold_code", {5'h00, detect_threshold_code}, 8'(c));
            chk("detect_preset_bit", {7'h00, detect_preset_bit}, {7'h00, c[1]});
            chk("detect_clear_bit", {7'h00, detect_clear_bit}, {7'h00, c[0]});
        end
        wr(`SDRT_ADDR_DETECT, `SDRT_RST_DETECT);
        // Eye DACs follow the sequencer without override and the register fields with it.
        for (int f = 0; f < 2; f++)
        begin
            pv = 6'($random(seed));
            vv = 6'($random(seed));
            wr(`SDRT_ADDR_EYE_ONE, {1'b0, 1'(f), pv});
            wr(`SDRT_ADDR_EYE_TWO, {2'b01, vv});
            for (int k = 0; k < 4; k++)
            begin
                {eye_auto_phase, eye_auto_voltage} = 12'($random(seed));
                settle(2);
                chk("eye_phase_dac auto", {2'b00, eye_phase_dac}, {2'b00, eye_auto_phase});
                chk("eye_voltage_dac auto", {2'b00, eye_voltage_dac}, {2'b00, eye_auto_voltage});
            end
            wr(`SDRT_ADDR_EYE_ONE, {1'b1, 1'(f), pv});
            {eye_auto_phase, eye_auto_voltage} = 12'($random(seed));
            settle(2);
            chk("eye_phase_dac override", {2'b00, eye_phase_dac}, {2'b00, pv});
            chk("eye_voltage_dac override", {2'b00, eye_voltage_dac}, {2'b00, vv});
            chk("eye_high_rate_filter", {7'h00, eye_high_rate_filter}, 8'(f));
        end
        end_of_test();
    end
endmodule : test_sdrt_cfg_bank
